//--- design/aps_regs.vh
`ifndef APS_REGS_VH
`define APS_REGS_VH
// serial frame, numbered 15 (first bit) down to 0
`define APS_BIT_WRITE    15
`define APS_SEL_MSB      14
`define APS_SEL_LSB      13
`define APS_SEL_CTRL     2'h0
`define APS_SEL_RANGE    2'h1
`define APS_SEL_MASK     2'h3
// control register, held as frame bits 11..0
`define APS_CTRL_MSB     11
`define APS_ADDR_HI      11
`define APS_ADDR_LO      10
`define APS_INMODE_HI    9
`define APS_INMODE_LO    8
`define APS_PM_HI        7
`define APS_PM_LO        6
`define APS_CODING       5
`define APS_REF          4
`define APS_SEQ_HI       3
`define APS_SEQ_LO       2
`define APS_RANGE_MSB    12
`define APS_RANGE_LSB    5
`define APS_MASK_MSB     12
`define APS_MASK_LSB     9
`define APS_CTRL_RST     12'h000
`define APS_RANGE_RST    8'h00
`define APS_MASK_RST     4'h0
`define APS_PM_NORMAL    2'h0
`define APS_PM_STANDBY   2'h1
`define APS_PM_AUTO_OFF  2'h2
`define APS_PM_FULL_OFF  2'h3
`define APS_SEQ_LIST     2'h1
`define APS_SEQ_CONSEC   2'h2
// edge counts inside a frame
`define APS_FALLS_COMMIT 5'h0D
`define APS_RISE_PWR     5'h0E
`define APS_CNT_MAX      5'h10
// clock edges after reset before pin edges are trusted
`define APS_WARM_DONE    2'h3
`define APS_RNG_10V      2'h0
`define APS_RNG_5V       2'h1
`define APS_RNG_2V5      2'h2
`define APS_RNG_UNI10    2'h3
`define APS_SEL_10V      4'h1
`define APS_SEL_5V       4'h2
`define APS_SEL_2V5      4'h4
`define APS_SEL_UNI10    4'h8
`endif

//--- design/aps_sync.v
`timescale 1ns/100ps
// two-flop synchroniser for asynchronous pins
module aps_sync #(
  parameter W = 3
) (
  input  wire         i_clk,
  input  wire         i_rst_n,
  input  wire [W-1:0] i_d,
  output wire [W-1:0] o_q
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end

  assign o_q = sync_q;
endmodule // aps_sync

//--- design/aps_next_chan.v
`timescale 1ns/100ps
// next channel of a running sequence, plus first channel of the list
module aps_next_chan (
  input  wire [3:0] i_mask,
  input  wire [1:0] i_cur,
  input  wire [1:0] i_last,
  input  wire       i_consec,
  output reg  [1:0] o_next,
  output reg  [1:0] o_first
);
  wire [3:0] above;
  integer    k;

  genvar c;
  generate
    for (c = 0; c < 4; c = c + 1) begin : g_above
      assign above[c] = i_mask[c] && (c > i_cur);
    end
  endgenerate

  always @* begin
    o_first = i_cur;
    o_next  = i_cur;
    // descending scan leaves the lowest match
    for (k = 3; k >= 0; k = k - 1) begin
      if (i_mask[k]) begin
        o_first = k[1:0];
      end
    end
    if (i_consec) begin
      o_next = (i_cur >= i_last) ? 2'h0 : i_cur + 2'h1;
    end else if (|above) begin
      for (k = 3; k >= 0; k = k - 1) begin
        if (above[k]) begin
          o_next = k[1:0];
        end
      end
    end else begin
      // wrap to the lowest flagged channel; empty list holds
      o_next = o_first;
    end
  end
endmodule // aps_next_chan

//--- design/aps_sequencer.v
// Contract
// [R1] power field 11 powers everything down until the field changes
// [R2] control register contents survive full shutdown
// [R3] power field 10 enters autoshutdown on 15th serial clock rising edge
// [R4] power field 01 enters autostandby, reference kept, on 15th rising edge
// [R5] power field 00 keeps all circuitry powered
// [R6] equal sequencer bits convert the channel named by the address bits
// [R7] sequencer 01 converts flagged channels, lowest first, ascending, wrapping
// [R8] list keeps cycling while mask and sequencer bits stay unchanged
// [R9] sequencer 10 cycles channels 0 up to the addressed last channel
// [R10] consecutive run continues through frames without write bit
// [R11] each converted channel uses its stored range code
// [R12] sequence mask holds four write-only bits, one per channel
// [R13] range register is eight bits, channel 0 code most significant
// [R14] write with select 01 loads the range register
// [R15] codes 00 10V, 01 5V, 10 2.5V, 11 unipolar 10V
// [R16] reset leaves every range code at the 10V setting
// [R17] a selected channel is configured to its stored range
// [R18] re-enabling list mode restarts at the first listed channel
// [R19] host leaves consecutive mode by clearing both sequencer bits
// [R20] write with select 11 loads four bits into the sequence mask
// [R21] control register write-only, reset zero, address 11:10, sequencer 3:2
`timescale 1ns/100ps
`include "aps_regs.vh"
module aps_sequencer (
  input  wire       i_clk,
  input  wire       i_rst_n,
  input  wire       i_cs_n,
  input  wire       i_sclk,
  input  wire       i_din,
  output reg        o_conv_start,
  output reg  [1:0] o_conv_chan,
  output reg  [1:0] o_conv_range,
  output reg  [3:0] o_range_sel,
  output wire       o_core_pwr,
  output wire       o_ref_pwr,
  output wire [3:0] o_pwr_state,
  output wire [1:0] o_in_mode,
  output wire       o_coding,
  output wire       o_ref_int,
  output wire       o_seq_active
);
  localparam [3:0] ST_AWAKE    = 4'h1;
  localparam [3:0] ST_FULL_OFF = 4'h2;
  localparam [3:0] ST_AUTO_OFF = 4'h4;
  localparam [3:0] ST_STANDBY  = 4'h8;

  wire [2:0]  pins_s;
  wire        cs_n_s;
  wire        sclk_s;
  wire        din_s;
  reg         cs_n_prev_q;
  reg         sclk_prev_q;
  wire        cs_fall;
  wire        cs_rise;
  wire        sclk_fall;
  wire        sclk_rise;
  reg  [1:0]  warm_q;
  wire        armed;
  reg         in_frame_q;
  reg  [14:0] shift_q;
  reg  [4:0]  falls_q;
  reg  [4:0]  rises_q;
  wire [15:0] frame_w;
  wire        commit;
  wire        pwr_edge;
  wire        wr_ctrl;
  wire        wr_range;
  wire        wr_mask;
  reg  [11:0] ctrl_q;
  reg  [7:0]  range_q;
  reg  [3:0]  mask_q;
  reg  [3:0]  st_q;
  reg  [3:0]  st_d;
  reg  [3:0]  pm_st;
  wire [7:0]  chan_code_w;
  reg  [1:0]  next_q;
  reg         restart_q;
  reg         restart_d;
  wire [1:0]  pm;
  wire [1:0]  seq;
  wire [1:0]  addr;
  wire [1:0]  new_seq;
  wire [1:0]  new_addr;
  wire        seq_list;
  wire        seq_consec;
  wire [1:0]  adv_chan;
  wire [1:0]  first_chan;
  reg  [1:0]  code_next;

  aps_sync #(
    .W (3)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_d     ({i_cs_n, i_sclk, i_din}),
    .o_q     (pins_s)
  );

  assign cs_n_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign din_s  = pins_s[0];

  // edge detectors look only at the second synchroniser stage
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_n_prev_q <= 1'b0;
      sclk_prev_q <= 1'b0;
    end else begin
      cs_n_prev_q <= cs_n_s;
      sclk_prev_q <= sclk_s;
    end
  end

  // synchroniser resets low while idle pins sit high; without this
  // warm-up the first settled sample would look like a select edge
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      warm_q <= 2'h0;
    end else if (warm_q != `APS_WARM_DONE) begin
      warm_q <= warm_q + 2'h1;
    end
  end

  assign armed     = (warm_q == `APS_WARM_DONE);
  assign cs_fall   = armed && cs_n_prev_q && !cs_n_s;
  assign cs_rise   = armed && !cs_n_prev_q && cs_n_s;
  assign sclk_fall = armed && sclk_prev_q && !sclk_s && in_frame_q;
  assign sclk_rise = armed && !sclk_prev_q && sclk_s && in_frame_q;

  // frame capture: data taken on falling serial clock edges
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      in_frame_q <= 1'b0;
      shift_q    <= 15'h0000;
      falls_q    <= 5'h00;
      rises_q    <= 5'h00;
    end else begin
      if (cs_fall) begin
        in_frame_q <= 1'b1;
        falls_q    <= 5'h00;
        rises_q    <= 5'h00;
      end else if (cs_rise) begin
        in_frame_q <= 1'b0;
      end
      if (sclk_fall) begin
        shift_q <= {shift_q[13:0], din_s};
        if (falls_q != `APS_CNT_MAX) begin
          falls_q <= falls_q + 5'h01;
        end
      end
      if (sclk_rise && rises_q != `APS_CNT_MAX) begin
        rises_q <= rises_q + 5'h01;
      end
    end
  end

  // fourteen bits are enough to decode; the last two are zero fill
  assign frame_w  = {shift_q[12:0], din_s, 2'h0};
  assign commit   = sclk_fall && (falls_q == `APS_FALLS_COMMIT);
  assign pwr_edge = sclk_rise && (rises_q == `APS_RISE_PWR);
  assign wr_ctrl  = commit && frame_w[`APS_BIT_WRITE] &&
                    (frame_w[`APS_SEL_MSB:`APS_SEL_LSB] == `APS_SEL_CTRL);
  assign wr_range = commit && frame_w[`APS_BIT_WRITE] &&
                    (frame_w[`APS_SEL_MSB:`APS_SEL_LSB] == `APS_SEL_RANGE);
  assign wr_mask  = commit && frame_w[`APS_BIT_WRITE] &&
                    (frame_w[`APS_SEL_MSB:`APS_SEL_LSB] == `APS_SEL_MASK);

  // write-only registers; frames without the write bit change nothing
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q  <= `APS_CTRL_RST;  // [R21]
      range_q <= `APS_RANGE_RST; // [R16]
      mask_q  <= `APS_MASK_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= frame_w[`APS_CTRL_MSB:0]; // [R21] [R2]
      end
      if (wr_range) begin
        range_q <= frame_w[`APS_RANGE_MSB:`APS_RANGE_LSB]; // [R14] [R13]
      end
      if (wr_mask) begin
        // channel 0 arrives first, so it sits highest in the frame
        mask_q <= {frame_w[`APS_MASK_LSB], frame_w[`APS_MASK_LSB+1],
                   frame_w[`APS_MASK_LSB+2], frame_w[`APS_MASK_MSB]}; // [R20] [R12]
      end
    end
  end

  assign pm         = ctrl_q[`APS_PM_HI:`APS_PM_LO];
  assign seq        = ctrl_q[`APS_SEQ_HI:`APS_SEQ_LO];
  assign addr       = ctrl_q[`APS_ADDR_HI:`APS_ADDR_LO];
  assign new_seq    = frame_w[`APS_SEQ_HI:`APS_SEQ_LO];
  assign new_addr   = frame_w[`APS_ADDR_HI:`APS_ADDR_LO];
  assign seq_list   = (seq == `APS_SEQ_LIST);
  assign seq_consec = (seq == `APS_SEQ_CONSEC);

  // state the power field asks for
  always @* begin
    case (pm)
      `APS_PM_FULL_OFF: pm_st = ST_FULL_OFF; // [R1]
      `APS_PM_AUTO_OFF: pm_st = ST_AUTO_OFF; // [R3]
      `APS_PM_STANDBY:  pm_st = ST_STANDBY;  // [R4]
      default:          pm_st = ST_AWAKE;    // [R5]
    endcase
  end

  // power state: decided at the 15th rising edge of every frame; autoshutdown and standby also wake at select rise
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_AWAKE: begin
        if (pwr_edge) begin
          st_d = pm_st;
        end
      end
      ST_FULL_OFF: begin
        // only a frame with a changed field leaves full shutdown
        if (pwr_edge) begin
          st_d = pm_st; // [R1]
        end
      end
      ST_AUTO_OFF: begin
        if (pwr_edge) begin
          st_d = pm_st;
        end else if (cs_rise) begin
          st_d = ST_AWAKE; // [R3]
        end
      end
      ST_STANDBY: begin
        if (pwr_edge) begin
          st_d = pm_st;
        end else if (cs_rise) begin
          st_d = ST_AWAKE; // [R4]
        end
      end
      default: begin
        st_d = ST_AWAKE;
      end
    endcase
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= ST_AWAKE;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_core_pwr  = (st_q == ST_AWAKE);               // [R5]
  assign o_ref_pwr   = (st_q == ST_AWAKE) || (st_q == ST_STANDBY); // [R4]
  assign o_pwr_state = st_q;

  aps_next_chan u_next (
    .i_mask   (mask_q),
    .i_cur    (next_q),
    .i_last   (addr),
    .i_consec (seq_consec),
    .o_next   (adv_chan),
    .o_first  (first_chan)
  );

  // restart on every mask write and control write, unless list mode, or consecutive mode with the same last channel, is kept
  always @* begin
    restart_d = 1'b0;
    if (wr_ctrl) begin
      if (new_seq == `APS_SEQ_LIST) begin
        restart_d = (seq != `APS_SEQ_LIST); // [R8] [R18]
      end else if (new_seq == `APS_SEQ_CONSEC) begin
        restart_d = (seq != `APS_SEQ_CONSEC) || (new_addr != addr); // [R10]
      end else begin
        restart_d = 1'b1; // [R6] [R19]
      end
    end
    if (wr_mask) begin
      restart_d = 1'b1; // [R8]
    end
  end

  // next_q is the channel the next frame will convert
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      restart_q <= 1'b0;
      next_q    <= 2'h0;
    end else begin
      restart_q <= restart_d;
      if (restart_q) begin
        if (seq_list) begin
          next_q <= first_chan; // [R7] [R18]
        end else if (seq_consec) begin
          next_q <= 2'h0; // [R9]
        end else begin
          next_q <= addr; // [R6]
        end
      end else if (cs_fall && (seq_list || seq_consec)) begin
        next_q <= adv_chan; // [R7] [R8] [R9] [R10]
      end
    end
  end

  // channel 0 code sits in the top field; regroup by channel number
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_code
      assign chan_code_w[g*2 +: 2] = range_q[(3-g)*2 +: 2]; // [R13]
    end
  endgenerate

  always @* begin
    code_next = chan_code_w[{next_q, 1'b0} +: 2];
  end

  // each conversion starts on chip-select fall with its own range
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_conv_start <= 1'b0;
      o_conv_chan  <= 2'h0;
      o_conv_range <= `APS_RNG_10V;
      o_range_sel  <= `APS_SEL_10V;
    end else begin
      o_conv_start <= cs_fall;
      if (cs_fall) begin
        o_conv_chan  <= next_q;
        o_conv_range <= code_next; // [R11] [R17]
        case (code_next)
          `APS_RNG_10V: o_range_sel <= `APS_SEL_10V; // [R15]
          `APS_RNG_5V:  o_range_sel <= `APS_SEL_5V;
          `APS_RNG_2V5: o_range_sel <= `APS_SEL_2V5;
          default:      o_range_sel <= `APS_SEL_UNI10;
        endcase
      end
    end
  end

  assign o_in_mode    = ctrl_q[`APS_INMODE_HI:`APS_INMODE_LO];
  assign o_coding     = ctrl_q[`APS_CODING];
  assign o_ref_int    = ctrl_q[`APS_REF];
  assign o_seq_active = seq_list || seq_consec;
endmodule // aps_sequencer

//--- sim/aps_sequencer_sva.sv
`timescale 1ns/100ps
module aps_sequencer_sva (
  input wire       i_clk,
  input wire       i_rst_n,
  input wire       i_cs_n,
  input wire       i_sclk,
  input wire       i_din,
  input wire       o_conv_start,
  input wire [1:0] o_conv_chan,
  input wire [1:0] o_conv_range,
  input wire [3:0] o_range_sel,
  input wire       o_core_pwr,
  input wire       o_ref_pwr,
  input wire [3:0] o_pwr_state,
  input wire [1:0] o_in_mode,
  input wire       o_coding,
  input wire       o_ref_int,
  input wire       o_seq_active
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_pwr_onehot: assert property ($onehot(o_pwr_state)) else $error("power state not one-hot");
  a_core_awake: assert property (o_core_pwr == o_pwr_state[0]) else $error("core power wrong");
  a_ref_kept: assert property (o_ref_pwr == (o_pwr_state[0] | o_pwr_state[3])) else $error("ref power wrong");
  a_range_decode: assert property (o_range_sel == (4'h1 << o_conv_range)) else $error("range select wrong");
  a_start_pulse: assert property (o_conv_start |=> !o_conv_start) else $error("start too long");
  a_start_follows: assert property ($fell(i_cs_n) |-> ##[2:6] o_conv_start) else $error("no start");
  a_start_in_frame: assert property (o_conv_start |-> !i_cs_n) else $error("start outside frame");
  a_chan_holds: assert property (!o_conv_start |-> $stable(o_conv_chan) && $stable(o_conv_range))
    else $error("channel moved without start");
  a_full_off_holds: assert property (o_pwr_state[1] && i_cs_n |=> o_pwr_state[1])
    else $error("left full shutdown");
  a_auto_wake: assert property ($rose(i_cs_n) && (o_pwr_state[2] || o_pwr_state[3]) |-> ##[1:8] o_pwr_state[0])
    else $error("no wake after select rise");

  c_auto_off: cover property (o_pwr_state[2]);
  c_standby: cover property (o_pwr_state[3]);
  c_seq_conv: cover property (o_seq_active && o_conv_start);
endmodule // aps_sequencer_sva

//--- sim/aps_host.sv
`timescale 1ns/100ps
module aps_host (
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_din
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b1;
    o_din  = 1'b0;
  end
  // msb first, data set while sclk high; select left low on return
  task automatic send(input logic [15:0] w);
    o_cs_n = 1'b0;
    #40;
    for (int i = 15; i >= 0; i--) begin
      o_din = w[i];
      #24;
      o_sclk = 1'b0;
      #24;
      o_sclk = 1'b1;
    end
    #30;
    // stale bit inverted so a late sample never looks valid
    o_din = ~o_din;
  endtask
  task automatic stop();
    o_cs_n = 1'b1;
    #60;
  endtask
endmodule // aps_host

//--- sim/test_aps_sequencer.sv
`timescale 1ns/100ps
module test_aps_sequencer;
  logic       i_clk;
  logic       i_rst_n;
  wire        i_cs_n, i_sclk, i_din;
  wire        o_conv_start, o_core_pwr, o_ref_pwr, o_coding, o_ref_int, o_seq_active;
  wire  [1:0] o_conv_chan, o_conv_range, o_in_mode;
  wire  [3:0] o_range_sel, o_pwr_state;
  int         err_count = 0;
  int         checks_done = 0;

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  aps_host aps_host_i (.o_cs_n(i_cs_n), .o_sclk(i_sclk), .o_din(i_din));
  aps_sequencer aps_sequencer_i (.i_clk, .i_rst_n, .i_cs_n, .i_sclk, .i_din, .o_conv_start, .o_conv_chan,
    .o_conv_range, .o_range_sel, .o_core_pwr, .o_ref_pwr, .o_pwr_state, .o_in_mode, .o_coding, .o_ref_int,
    .o_seq_active);

  task chk(input string nm, input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task frame(input logic [15:0] w);
    aps_host_i.send(w);
    aps_host_i.stop();
    repeat (8) @(posedge i_clk);
  endtask
  task conv(input logic [15:0] w, input logic [1:0] ch, input logic [1:0] rng);
    frame(w);
    chk("channel", {2'h0, o_conv_chan}, {2'h0, ch});
    chk("range code", {2'h0, o_conv_range}, {2'h0, rng});
    chk("range select", o_range_sel, 4'h1 << rng);
  endtask
  task hold(input logic [15:0] w, input logic [3:0] st, input logic [1:0] pw);
    aps_host_i.send(w);
    chk("power state", o_pwr_state, st);
    chk("core and ref", {2'h0, o_core_pwr, o_ref_pwr}, {2'h0, pw});
    aps_host_i.stop();
    repeat (8) @(posedge i_clk);
  endtask

  task t_reset();
    chk("power state", o_pwr_state, 4'h1);
    chk("range code", {2'h0, o_conv_range}, 4'h0);
    chk("mode flags", {o_in_mode, o_coding, o_seq_active}, 4'h0);
    $display("test reset done");
  endtask
  task t_list();
    frame(16'hAD80);
    frame(16'hEA00);
    frame(16'h8004);
    chk("seq active", {3'h0, o_seq_active}, 4'h1);
    conv(16'h0000, 2'h1, 2'h2);
    conv(16'h0000, 2'h3, 2'h0);
    conv(16'h0000, 2'h1, 2'h2);
    frame(16'h8000);
    conv(16'h0000, 2'h0, 2'h1);
    frame(16'hBFE0);
    frame(16'h8004);
    conv(16'h0000, 2'h1, 2'h3);
    $display("test list done");
  endtask
  task t_consec();
    frame(16'h8808);
    conv(16'h7FFF, 2'h0, 2'h3);
    conv(16'h0000, 2'h1, 2'h3);
    conv(16'h7FFF, 2'h2, 2'h3);
    conv(16'h0000, 2'h0, 2'h3);
    frame(16'h840C);
    chk("seq active", {3'h0, o_seq_active}, 4'h0);
    conv(16'h0000, 2'h1, 2'h3);
    conv(16'h0000, 2'h1, 2'h3);
    $display("test consec done");
  endtask
  task t_power();
    hold(16'h8080, 4'h4, 2'h0);
    chk("awake", o_pwr_state, 4'h1);
    hold(16'h8040, 4'h8, 2'h1);
    hold(16'h83F0, 4'h2, 2'h0);
    hold(16'h0000, 4'h2, 2'h0);
    chk("held config", {o_in_mode, o_coding, o_ref_int}, 4'hF);
    hold(16'h8000, 4'h1, 2'h3);
    $display("test power done");
  endtask

  task test_done();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    i_rst_n <= 1'b0;
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    t_reset();
    t_list();
    t_consec();
    t_power();
    test_done();
  end

  // twenty-four frames of under a microsecond each
  initial begin
    #100000;
    err_count++;
    test_done();
  end
endmodule // test_aps_sequencer

bind aps_sequencer aps_sequencer_sva aps_sequencer_sva_i (.i_clk, .i_rst_n, .i_cs_n, .i_sclk, .i_din,
  .o_conv_start, .o_conv_chan, .o_conv_range, .o_range_sel, .o_core_pwr, .o_ref_pwr, .o_pwr_state,
  .o_in_mode, .o_coding, .o_ref_int, .o_seq_active);
